/* File: ttg_map.svh */
// Contract
// [RL1] toggle pin when active duration expires
// [RL2] start keeps existing pin level unforced
// [RL3] programmable start delay in current unit
// [RL4] repeat count sets toggles, up to billion
// [RL5] repeat zero default, means one billion
// [RL6] one to eight durations, one load
// [RL7] software keeps durations inside unit range
// [RL8] start without durations reports an error
// [RL9] durations reused circularly, last wraps first
// [RL10] pin low after select, reset, force-low
// [RL11] force commands drive pin at once
// [RL12] software selects output pin before use
// [RL13] push-pull or open-drain, push-pull default
// [RL14] invert applies to waveform and forces
// [RL15] invert change toggles pin at once
// [RL16] invert disabled after initialization
// [RL17] start may follow channel zero..seven
// [RL18] default trigger none, software start only
// [RL19] remaining toggle count readable by software
// [RL20] each duration spans previous event to toggle
// [RL21] reset command stops, clears, drives low
// [RL22] stop halts at once, pin holds
// [RL23] state reads zero stopped, nonzero running
// [RL24] unit sec, ms or us, ms default
// [RL25] after last toggle stop, hold level
`ifndef TTG_MAP_SVH
`define TTG_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TTG_OFS_CTRL 8'h00
`define TTG_OFS_CFG 8'h04
`define TTG_OFS_PINSEL 8'h08
`define TTG_OFS_DELAY 8'h0C
`define TTG_OFS_REPC 8'h10
`define TTG_OFS_DURCNT 8'h14
`define TTG_OFS_STATUS 8'h18
`define TTG_DUR_PAGE 3'h1
`define TTG_ADDR_ZERO 2'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define TTG_CTRL_START 0
`define TTG_CTRL_STOP 1
`define TTG_CTRL_RESET 2
`define TTG_CTRL_FLOW 3
`define TTG_CTRL_FHIGH 4
`define TTG_CFG_UNIT_LSB 0
`define TTG_CFG_UNIT_MSB 1
`define TTG_CFG_OD 2
`define TTG_CFG_INV 3
`define TTG_CFG_TRIG_LSB 4
`define TTG_CFG_TRIG_MSB 6
`define TTG_CFG_TRIG_EN 7
`define TTG_STAT_ERR 8

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define TTG_CFG_RST 8'h01
`define TTG_UNIT_SEC 2'h0
`define TTG_UNIT_MS 2'h1
`define TTG_UNIT_US 2'h2
`define TTG_STATE_STOP 3'h0
`define TTG_STATE_DELAY 3'h1
`define TTG_STATE_RUN 3'h2
`define TTG_MAX_REPC 30'd1000000000
`define TTG_DURCNT_MAX 4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define TTG_CLK_NS 10
`define TTG_US_NS 1000
`define TTG_US_CYC ((`TTG_US_NS + `TTG_CLK_NS - 1) / `TTG_CLK_NS)
`define TTG_SUB_PER_UNIT 1000

`endif

/* File: ttg_pkg.sv */
`default_nettype none
package ttg_pkg;
    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ttg_apb_req_t;

    // apb answer, all registered
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ttg_apb_rsp_t;

    // sequencing states
    typedef enum logic [1:0] {
        TTG_IDLE,
        TTG_DELAY,
        TTG_RUN
    } ttg_state_t;
endpackage
`default_nettype wire

/* File: ttg_output_timer.sv */
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ttg_map.svh"

module ttg_output_timer #(
    parameter int NUM_PINS = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register bus
    input wire ttg_pkg::ttg_apb_req_t apbReq,
    output var ttg_pkg::ttg_apb_rsp_t apbRsp,
    // start links to sibling channels
    input wire logic [7:0] trigIn,
    output logic startOut,
    // digital_io_port pins
    output logic [NUM_PINS-1:0] pinOut,
    output logic [NUM_PINS-1:0] pinOe
);
    import ttg_pkg::*;

    localparam int PIN_W = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;

    // ----------------------------------------
    // state
    // ----------------------------------------
    ttg_apb_rsp_t rsp_reg, rsp_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [PIN_W-1:0] pinSel_reg, pinSel_next;
    logic [31:0] delay_reg, delay_next;
    logic [29:0] repc_reg, repc_next;
    logic [3:0] durCnt_reg, durCnt_next;
    logic durLoaded_reg, durLoaded_next;
    logic [30:0] dur_reg [8];
    logic [30:0] dur_next [8];
    logic err_reg, err_next;
    ttg_state_t state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [2:0] idx_reg, idx_next;
    logic [29:0] rem_reg, rem_next;
    logic level_reg, level_next;
    logic start_reg, start_next;
    logic [NUM_PINS-1:0] pinOut_reg, pinOut_next;
    logic [NUM_PINS-1:0] pinOe_reg, pinOe_next;
    logic [15:0] usCnt_reg, usCnt_next;
    logic [15:0] msCnt_reg, msCnt_next;
    logic [15:0] secCnt_reg, secCnt_next;

    // decoded strobes
    logic wrEn, setupRd, addrHit, durHit;
    logic cmdStart, cmdStop, cmdReset, cmdFlow, cmdFhigh;
    logic cfgWr, pinSelWr, trigHit, startReq, goStart;
    logic usTick, msTick, secTick, unitTick;
    logic [31:0] cntInc;
    logic durDone, toggleEv, invChg;

    assign apbRsp = rsp_reg;
    assign startOut = start_reg;
    assign pinOut = pinOut_reg;
    assign pinOe = pinOe_reg;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // write lands only at the access edge that sees pready
    assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite & rsp_reg.pready;
    assign setupRd = apbReq.psel & ~apbReq.penable;
    assign durHit = (apbReq.paddr[7:5] == `TTG_DUR_PAGE) &&
        (apbReq.paddr[1:0] == `TTG_ADDR_ZERO);
    assign addrHit = durHit ||
        (apbReq.paddr == `TTG_OFS_CTRL) || (apbReq.paddr == `TTG_OFS_CFG) ||
        (apbReq.paddr == `TTG_OFS_PINSEL) || (apbReq.paddr == `TTG_OFS_DELAY) ||
        (apbReq.paddr == `TTG_OFS_REPC) || (apbReq.paddr == `TTG_OFS_DURCNT) ||
        (apbReq.paddr == `TTG_OFS_STATUS);

    // command strobes, one pulse per written one
    always_comb begin
        cmdStart = wrEn && (apbReq.paddr == `TTG_OFS_CTRL) && apbReq.pwdata[`TTG_CTRL_START];
        cmdStop = wrEn && (apbReq.paddr == `TTG_OFS_CTRL) && apbReq.pwdata[`TTG_CTRL_STOP];
        cmdReset = wrEn && (apbReq.paddr == `TTG_OFS_CTRL) && apbReq.pwdata[`TTG_CTRL_RESET];
        cmdFlow = wrEn && (apbReq.paddr == `TTG_OFS_CTRL) && apbReq.pwdata[`TTG_CTRL_FLOW];
        cmdFhigh = wrEn && (apbReq.paddr == `TTG_OFS_CTRL) && apbReq.pwdata[`TTG_CTRL_FHIGH];
        cfgWr = wrEn && (apbReq.paddr == `TTG_OFS_CFG);
        pinSelWr = wrEn && (apbReq.paddr == `TTG_OFS_PINSEL);
    end

    // sibling start only when a source is enabled
    assign trigHit = cfg_reg[`TTG_CFG_TRIG_EN] &&
        trigIn[cfg_reg[`TTG_CFG_TRIG_MSB:`TTG_CFG_TRIG_LSB]]; // RL17 RL18
    assign startReq = (cmdStart | trigHit) & ~cmdStop & ~cmdReset;
    assign goStart = startReq & durLoaded_reg; // RL8

    // ----------------------------------------
    // unit prescaler
    // ----------------------------------------
    // chained us/ms/sec dividers keep every counter small
    assign usTick = (usCnt_reg == 16'(`TTG_US_CYC - 1));
    assign msTick = usTick && (msCnt_reg == 16'(`TTG_SUB_PER_UNIT - 1));
    assign secTick = msTick && (secCnt_reg == 16'(`TTG_SUB_PER_UNIT - 1));

    always_comb begin
        case (cfg_reg[`TTG_CFG_UNIT_MSB:`TTG_CFG_UNIT_LSB]) // RL24
            `TTG_UNIT_SEC: unitTick = secTick;
            `TTG_UNIT_US: unitTick = usTick;
            default: unitTick = msTick;
        endcase
    end

    // prescaler restarts with the timer so first unit is whole
    always_comb begin
        usCnt_next = usTick ? 16'h0000 : usCnt_reg + 16'h0001;
        msCnt_next = !usTick ? msCnt_reg : (msTick ? 16'h0000 : msCnt_reg + 16'h0001);
        secCnt_next = !msTick ? secCnt_reg : (secTick ? 16'h0000 : secCnt_reg + 16'h0001);
        if (goStart) begin
            usCnt_next = 16'h0000;
            msCnt_next = 16'h0000;
            secCnt_next = 16'h0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            usCnt_reg <= 16'h0000;
            msCnt_reg <= 16'h0000;
            secCnt_reg <= 16'h0000;
        end else begin
            usCnt_reg <= usCnt_next;
            msCnt_reg <= msCnt_next;
            secCnt_reg <= secCnt_next;
        end
    end

    // ----------------------------------------
    // sequencer and configuration
    // ----------------------------------------
    assign cntInc = cnt_reg + 32'h0000_0001;
    assign durDone = cntInc >= {1'b0, dur_reg[idx_reg]}; // RL20
    assign toggleEv = (state_reg == TTG_RUN) && unitTick && durDone;
    assign invChg = cfgWr && (apbReq.pwdata[`TTG_CFG_INV] != cfg_reg[`TTG_CFG_INV]);

    always_comb begin
        cfg_next = cfg_reg;
        pinSel_next = pinSel_reg;
        delay_next = delay_reg;
        repc_next = repc_reg;
        durCnt_next = durCnt_reg;
        durLoaded_next = durLoaded_reg;
        dur_next = dur_reg;
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        rem_next = rem_reg;
        level_next = level_reg;
        start_next = 1'b0;
        // error flag: a new failed start beats a clear
        err_next = err_reg;
        if (wrEn && (apbReq.paddr == `TTG_OFS_STATUS) && apbReq.pwdata[`TTG_STAT_ERR]) begin
            err_next = 1'b0;
        end
        if (startReq && !durLoaded_reg) begin
            err_next = 1'b1; // RL8
        end
        // plain register writes
        if (cfgWr) begin
            cfg_next = apbReq.pwdata[7:0]; // RL13 RL24
        end
        if (pinSelWr) begin
            pinSel_next = apbReq.pwdata[PIN_W-1:0];
        end
        if (wrEn && (apbReq.paddr == `TTG_OFS_DELAY)) begin
            delay_next = apbReq.pwdata;
        end
        if (wrEn && (apbReq.paddr == `TTG_OFS_REPC)) begin
            repc_next = apbReq.pwdata[29:0]; // RL4
        end
        if (wrEn && durHit) begin
            dur_next[apbReq.paddr[4:2]] = apbReq.pwdata[30:0]; // RL6
        end
        // count write commits the list; out of range unloads it
        if (wrEn && (apbReq.paddr == `TTG_OFS_DURCNT)) begin
            durCnt_next = apbReq.pwdata[3:0];
            durLoaded_next = (apbReq.pwdata[3:0] != 4'h0) &&
                (apbReq.pwdata[3:0] <= `TTG_DURCNT_MAX); // RL6
        end
        // sequencing
        case (state_reg)
            TTG_IDLE: cnt_next = 32'h0000_0000;
            TTG_DELAY: begin
                if (unitTick) begin
                    if (cntInc >= delay_reg) begin
                        state_next = TTG_RUN; // RL3
                        cnt_next = 32'h0000_0000;
                    end else begin
                        cnt_next = cntInc;
                    end
                end
            end
            TTG_RUN: begin
                if (toggleEv) begin
                    level_next = ~level_reg; // RL1
                    cnt_next = 32'h0000_0000; // RL20
                    rem_next = rem_reg - 30'h0000_0001;
                    // wrap back to the first entry after the last
                    if ({1'b0, idx_reg} == durCnt_reg - 4'h1) begin
                        idx_next = 3'h0; // RL9
                    end else begin
                        idx_next = idx_reg + 3'h1;
                    end
                    if (rem_reg <= 30'h0000_0001) begin
                        state_next = TTG_IDLE; // RL25
                    end
                end else if (unitTick) begin
                    cnt_next = cntInc;
                end
            end
            default: state_next = TTG_IDLE;
        endcase
        // start leaves the pin alone so waveform follows it
        if (goStart) begin
            state_next = (delay_reg == 32'h0000_0000) ? TTG_RUN : TTG_DELAY; // RL2 RL3
            cnt_next = 32'h0000_0000;
            idx_next = 3'h0;
            rem_next = (repc_reg == 30'h0000_0000) ? `TTG_MAX_REPC : repc_reg; // RL4 RL5
            start_next = 1'b1; // RL17
        end
        if (cmdStop) begin
            state_next = TTG_IDLE; // RL22
            level_next = level_reg; // toggle due in this cycle is dropped
        end
        // level overrides, strongest last
        if (invChg) begin
            level_next = ~level_next; // RL15
        end
        if (cmdFlow) begin
            level_next = cfg_next[`TTG_CFG_INV]; // RL11 RL14
        end
        if (cmdFhigh) begin
            level_next = ~cfg_next[`TTG_CFG_INV]; // RL11 RL14
        end
        if (pinSelWr) begin
            level_next = 1'b0; // RL10
        end
        if (cmdReset) begin
            state_next = TTG_IDLE; // RL21
            cnt_next = 32'h0000_0000;
            idx_next = 3'h0;
            rem_next = 30'h0000_0000;
            level_next = 1'b0; // RL10 RL21
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // open-drain only ever pulls low, releases for high
    for (genvar g = 0; g < NUM_PINS; g++) begin : gPin
        always_comb begin
            if (pinSel_next == PIN_W'(g)) begin
                pinOut_next[g] = cfg_next[`TTG_CFG_OD] ? 1'b0 : level_next; // RL13
                pinOe_next[g] = cfg_next[`TTG_CFG_OD] ? ~level_next : 1'b1; // RL13
            end else begin
                pinOut_next[g] = 1'b0;
                pinOe_next[g] = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    // data sampled in setup so access phase needs no wait
    always_comb begin
        rsp_next.pready = setupRd;
        rsp_next.pslverr = setupRd & ~addrHit;
        rsp_next.prdata = 32'h0000_0000;
        if (setupRd && !apbReq.pwrite) begin
            if (durHit) begin
                rsp_next.prdata = {1'b0, dur_reg[apbReq.paddr[4:2]]};
            end else begin
                case (apbReq.paddr)
                    `TTG_OFS_CFG: rsp_next.prdata = {24'h00_0000, cfg_reg};
                    `TTG_OFS_PINSEL: rsp_next.prdata = 32'(pinSel_reg);
                    `TTG_OFS_DELAY: rsp_next.prdata = delay_reg;
                    `TTG_OFS_REPC: rsp_next.prdata = {2'h0, rem_reg}; // RL19
                    `TTG_OFS_DURCNT: rsp_next.prdata = {28'h000_0000, durCnt_reg};
                    `TTG_OFS_STATUS: begin
                        rsp_next.prdata[`TTG_STAT_ERR] = err_reg;
                        case (state_reg) // RL23
                            TTG_DELAY: rsp_next.prdata[2:0] = `TTG_STATE_DELAY;
                            TTG_RUN: rsp_next.prdata[2:0] = `TTG_STATE_RUN;
                            default: rsp_next.prdata[2:0] = `TTG_STATE_STOP;
                        endcase
                    end
                    default: rsp_next.prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rsp_reg <= '0;
            cfg_reg <= `TTG_CFG_RST; // RL16 RL18 RL24
            pinSel_reg <= '0;
            delay_reg <= 32'h0000_0000;
            repc_reg <= 30'h0000_0000; // RL5
            durCnt_reg <= 4'h0;
            durLoaded_reg <= 1'b0;
            dur_reg <= '{default: 31'h0000_0000};
            err_reg <= 1'b0;
            state_reg <= TTG_IDLE;
            cnt_reg <= 32'h0000_0000;
            idx_reg <= 3'h0;
            rem_reg <= 30'h0000_0000;
            level_reg <= 1'b0; // RL10
            start_reg <= 1'b0;
            pinOut_reg <= '0;
            pinOe_reg <= NUM_PINS'(1'b1); // RL10 RL13
        end else begin
            rsp_reg <= rsp_next;
            cfg_reg <= cfg_next;
            pinSel_reg <= pinSel_next;
            delay_reg <= delay_next;
            repc_reg <= repc_next;
            durCnt_reg <= durCnt_next;
            durLoaded_reg <= durLoaded_next;
            dur_reg <= dur_next;
            err_reg <= err_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            rem_reg <= rem_next;
            level_reg <= level_next;
            start_reg <= start_next;
            pinOut_reg <= pinOut_next;
            pinOe_reg <= pinOe_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    toggle_on_expiry_a: assert property ( // RL1
        toggleEv && !wrEn |=> level_reg != $past(level_reg))
        else $error("pin did not toggle at expiry");
    start_keeps_level_a: assert property ( // RL2
        goStart && !cmdFlow && !cmdFhigh && !invChg && !pinSelWr |=> level_reg == $past(level_reg))
        else $error("start changed pin level");
    delay_quiet_a: assert property ( // RL3
        state_reg == TTG_DELAY && !wrEn |=> level_reg == $past(level_reg))
        else $error("pin moved during delay");
    rem_count_a: assert property ( // RL4
        toggleEv && !wrEn |=> rem_reg == $past(rem_reg) - 30'h0000_0001)
        else $error("remaining count not decremented");
    zero_repc_a: assert property ( // RL5
        goStart && repc_reg == 30'h0000_0000 |=> rem_reg == `TTG_MAX_REPC)
        else $error("zero repeat not taken as maximum");
    no_list_err_a: assert property ( // RL8
        startReq && !durLoaded_reg |=> err_reg && state_reg == $past(state_reg))
        else $error("start without durations not refused");
    idx_wrap_a: assert property ( // RL9
        toggleEv && !cmdReset && {1'b0, idx_reg} == durCnt_reg - 4'h1 |=> idx_reg == 3'h0)
        else $error("duration index did not wrap");
    force_high_a: assert property ( // RL11
        cmdFhigh && !cmdReset && !pinSelWr |=> level_reg == !cfg_reg[`TTG_CFG_INV] ##1
        pinOut_reg[pinSel_reg] == (cfg_reg[`TTG_CFG_OD] ? 1'b0 : level_reg))
        else $error("force high level wrong");
    inv_toggle_a: assert property ( // RL15
        invChg && !toggleEv && !cmdFlow && !cmdFhigh && !cmdReset && !pinSelWr
        |=> level_reg != $past(level_reg))
        else $error("invert change did not toggle pin");
    reset_cmd_a: assert property ( // RL21
        cmdReset |=> level_reg == 1'b0 && state_reg == TTG_IDLE && rem_reg == 30'h0000_0000)
        else $error("reset command did not clear");
    stop_hold_a: assert property ( // RL22
        cmdStop && !cmdReset && !cmdFlow && !cmdFhigh && !invChg && !pinSelWr
        |=> state_reg == TTG_IDLE && level_reg == $past(level_reg))
        else $error("stop did not halt with level held");
    done_idle_a: assert property ( // RL25
        toggleEv && rem_reg == 30'h0000_0001 && !goStart |=> state_reg == TTG_IDLE)
        else $error("did not stop after last toggle");

    run_wrap_c: cover property (toggleEv && idx_reg == 3'h7);
    delay_run_c: cover property (state_reg == TTG_DELAY ##1 state_reg == TTG_RUN);
    trig_start_c: cover property (trigHit && goStart);
    finish_c: cover property (state_reg == TTG_RUN ##1 state_reg == TTG_IDLE);
endmodule // ttg_output_timer
`default_nettype wire

/* File: ttg_pin_load.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// external load with pull-up
// ----
module ttg_pin_load #(
    parameter int NUM_PINS = 8
) (
    // driver side
    input wire logic [NUM_PINS-1:0] pinOut,
    input wire logic [NUM_PINS-1:0] pinOe,
    // resolved wire
    output logic [NUM_PINS-1:0] pinLevel
);
    // a released pin floats up, so open-drain high still reads 1
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pinLevel[i] = pinOe[i] ? pinOut[i] : 1'b1;
        end
    end
endmodule // ttg_pin_load
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ttg_map.svh"
module tb;
    import ttg_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    ttg_apb_req_t apbReq = '0;
    ttg_apb_rsp_t apbRsp;
    logic [7:0] trigIn = 8'h00;
    logic startOut;
    logic [7:0] pinOut, pinOe, pinLevel;
    int miscompares = 0;
    int cmpCount = 0;
    int cyc = 0;
    int pSel = 0;
    logic [31:0] rdat;
    logic rerr;

    // ----
    // clock, design and load
    // ----
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    ttg_output_timer #(.NUM_PINS(8)) i_ttg_output_timer (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .apbReq(apbReq), .apbRsp(apbRsp), .trigIn(trigIn), .startOut(startOut),
        .pinOut(pinOut), .pinOe(pinOe));
    ttg_pin_load #(.NUM_PINS(8)) i_ttg_pin_load (.pinOut(pinOut), .pinOe(pinOe),
        .pinLevel(pinLevel));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is sampled high, bounded wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        rdat = apbRsp.prdata;
        rerr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    // pin is registered, so allow two extra edges before looking
    task automatic wrPin(input logic [7:0] a, input logic [31:0] d, input logic exp);
        apb(1'b1, a, d);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, pinLevel[pSel]}, {31'h0, exp});
    endtask

    task automatic waitTog(input int lim, output int t);
        logic old;
        int n;
        old = pinOut[pSel];
        n = 0;
        while (pinOut[pSel] === old && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= lim) chk(32'h0, 32'h1);
        t = cyc;
    endtask

    task automatic trig(input logic [7:0] m, input logic exp);
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk);
        trigIn <= m;
        @(posedge ref_clk);
        trigIn <= 8'h00;
        repeat (3) begin
            @(posedge ref_clk);
            seen |= startOut;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog, well beyond the expected run of some 12000 cycles
    initial begin
        repeat (80000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end

    // ----
    // main sequence
    // ----
    initial begin
        int dur[3];
        int t0, t1, t2, k;
        void'($urandom(98984));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`TTG_OFS_CFG, 32'h1);
        rd(`TTG_OFS_REPC, 32'h0);
        rd(`TTG_OFS_STATUS, 32'h0);
        chk({24'h0, pinOe}, 32'h1);
        chk({24'h0, pinOut}, 32'h0);
        apb(1'b1, `TTG_OFS_CTRL, 32'h1);
        rd(`TTG_OFS_STATUS, 32'h100);
        apb(1'b1, `TTG_OFS_STATUS, 32'h100);
        rd(`TTG_OFS_STATUS, 32'h0);
        rd(8'h1C, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // microsecond unit keeps every wait short
        pSel = $urandom_range(7);
        apb(1'b1, `TTG_OFS_CFG, 32'h2);
        wrPin(`TTG_OFS_PINSEL, pSel, 1'b0);
        for (k = 0; k < 3; k++) begin
            dur[k] = 10 + $urandom_range(5);
            apb(1'b1, 8'h20 + 8'(4 * k), dur[k]);
        end
        apb(1'b1, `TTG_OFS_DURCNT, 32'h3);
        apb(1'b1, `TTG_OFS_REPC, 32'h5);
        apb(1'b1, `TTG_OFS_DELAY, 32'h2);
        apb(1'b1, `TTG_OFS_CTRL, 32'h1);
        t0 = cyc;
        rd(`TTG_OFS_STATUS, 32'h1);
        waitTog(3000, t1);
        chk((t1 - t0 - (2 + dur[0]) * 100) inside {[-1:3]}, 32'h1);
        rd(`TTG_OFS_REPC, 32'h4);
        rd(`TTG_OFS_STATUS, 32'h2);
        for (k = 1; k < 5; k++) begin
            waitTog(3000, t2);
            chk(t2 - t1, dur[k % 3] * 100);
            t1 = t2;
        end
        repeat (10) @(posedge ref_clk);
        rd(`TTG_OFS_STATUS, 32'h0);
        rd(`TTG_OFS_REPC, 32'h0);
        repeat (1600) @(posedge ref_clk);
        chk({31'h0, pinOut[pSel]}, 32'h1);
        wrPin(`TTG_OFS_CTRL, 32'h8, 1'b0);
        wrPin(`TTG_OFS_CTRL, 32'h10, 1'b1);
        wrPin(`TTG_OFS_CFG, 32'hA, 1'b0);
        wrPin(`TTG_OFS_CTRL, 32'h10, 1'b0);
        wrPin(`TTG_OFS_CTRL, 32'h8, 1'b1);
        wrPin(`TTG_OFS_CFG, 32'h2, 1'b0);
        wrPin(`TTG_OFS_CFG, 32'h6, 1'b0);
        wrPin(`TTG_OFS_CTRL, 32'h10, 1'b1);
        chk({31'h0, pinOe[pSel]}, 32'h0);
        apb(1'b1, `TTG_OFS_CFG, 32'h2);
        pSel = (pSel + 1) % 8;
        wrPin(`TTG_OFS_PINSEL, pSel, 1'b0);
        chk({24'h0, pinOut}, 32'h0);
        apb(1'b1, `TTG_OFS_REPC, 32'h0);
        apb(1'b1, `TTG_OFS_CTRL, 32'h1);
        rd(`TTG_OFS_REPC, 32'd1000000000);
        waitTog(3000, t1);
        apb(1'b1, `TTG_OFS_CTRL, 32'h2);
        repeat (2000) @(posedge ref_clk);
        rd(`TTG_OFS_STATUS, 32'h0);
        chk({31'h0, pinOut[pSel]}, 32'h1);
        // disabled trigger and wrong channels must not start it
        trig(8'hFF, 1'b0);
        for (k = 0; k < 8; k++) begin
            apb(1'b1, `TTG_OFS_CFG, 32'h82 | (k << 4));
            trig(8'h1 << ((k + 1) % 8), 1'b0);
            trig(8'h1 << k, 1'b1);
            apb(1'b0, `TTG_OFS_STATUS, 32'h0);
            chk(rdat != 32'h0, 32'h1);
            chk({31'h0, pinOut[pSel]}, 32'h1);
            apb(1'b1, `TTG_OFS_CTRL, 32'h2);
        end
        wrPin(`TTG_OFS_CTRL, 32'h10, 1'b1);
        wrPin(`TTG_OFS_CTRL, 32'h4, 1'b0);
        rd(`TTG_OFS_STATUS, 32'h0);
        end_sim();
    end
endmodule // tb
`default_nettype wire
